// ### logic/tbp_pkg.sv
// shared constants and types of the trace buffer playback block
package tbp_pkg;
    localparam int TBP_LINES = 128;
    localparam int TBP_CHANNELS = 8;
    localparam int TBP_DATA_W = 16;
    localparam int TBP_IDX_W = 7;
    localparam int TBP_PLAY_CH = 4;
    localparam int TBP_INTERVAL_W = 7;
    localparam int TBP_SPEED_W = 8;
    localparam int TBP_COUNT_W = 8;

    localparam logic [6:0] TBP_LAST_IDX = 7'h7F;
    localparam logic [6:0] TBP_READ_MAX_IDX = 7'h63;
    localparam logic [6:0] TBP_IDX_ZERO = 7'h00;
    localparam logic [6:0] TBP_IDX_ONE = 7'h01;
    localparam logic [7:0] TBP_COUNT_FULL = 8'h80;
    localparam logic [7:0] TBP_REPLAY_FN = 8'h13;
    localparam logic [1:0] TBP_MODE_SINGLE = 2'h1;
    localparam logic [1:0] TBP_MODE_CONT = 2'h2;
    localparam logic TBP_FMT_HEX = 1'b0;
    localparam logic TBP_FMT_PCT = 1'b1;

    // percent display in tenths of a percent; 16384 is full scale
    localparam logic signed [26:0] TBP_PCT_TENTHS = 27'sh0_03E8;
    localparam int TBP_FULL_SCALE_SHIFT = 14;
    localparam logic [15:0] TBP_DATA_RESET = 16'h0000;

    localparam int TBP_CLK_HZ = 10_000_000;
    localparam int TBP_REPLAY_BASE_HZ = 300;
    localparam int TBP_REPLAY_BASE_CYC = TBP_CLK_HZ / TBP_REPLAY_BASE_HZ;

    typedef enum logic [2:0] {
        TBP_RP_IDLE = 3'b001,
        TBP_RP_ARMED = 3'b010,
        TBP_RP_PLAY = 3'b100
    } tbp_replay_state_t;

    typedef logic [TBP_PLAY_CH-1:0][TBP_DATA_W-1:0] tbp_play_data_t;
endpackage

// ### logic/tbp_play_if.sv
// replay fetch path between the trace store and the replay engine
`timescale 1ns/1ps
interface tbp_play_if;
    import tbp_pkg::*;
    logic [TBP_IDX_W-1:0] rd_idx;
    tbp_play_data_t rd_data;
    modport store (input rd_idx, output rd_data);
    modport player (output rd_idx, input rd_data);
endinterface

// ### logic/tbp_replay.sv
// analog replay engine: panel key sequence, rate divider, four output slots
`timescale 1ns/1ps
module tbp_replay #(
    parameter int BASE_CYC = tbp_pkg::TBP_REPLAY_BASE_CYC
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    tbp_play_if.player play,
    input wire logic [7:0] panel_function_selector_i,
    input wire logic select_key_i,
    input wire logic raise_key_i,
    input wire logic lower_key_i,
    input wire logic [tbp_pkg::TBP_SPEED_W-1:0] replay_speed_div_i,
    input wire logic [1:0] replay_mode_sel_i,
    output tbp_pkg::tbp_play_data_t aout_o,
    output logic active_o
);
    import tbp_pkg::*;

    localparam int BW = $clog2(BASE_CYC + 1);
    localparam logic [BW-1:0] BASE_LAST = BW'(BASE_CYC - 1);

    tbp_replay_state_t state;
    logic [TBP_IDX_W-1:0] idx;
    logic [BW-1:0] base_cnt;
    logic [TBP_SPEED_W-1:0] div_cnt;
    logic [TBP_SPEED_W-1:0] div_last;
    logic tick;

    // a speed of zero would stall forever, so it behaves as the fastest rate
    assign div_last = (replay_speed_div_i == '0) ? '0 : replay_speed_div_i - 8'h01;
    assign tick = (base_cnt == BASE_LAST) && (div_cnt >= div_last);
    assign play.rd_idx = idx;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            base_cnt <= '0;
            div_cnt <= '0;
        end else if (state != TBP_RP_PLAY || tick) begin
            base_cnt <= '0;
            div_cnt <= '0;
        end else if (base_cnt == BASE_LAST) begin
            base_cnt <= '0;
            div_cnt <= div_cnt + 8'h01; // RULE10
        end else begin
            base_cnt <= base_cnt + BW'(1);
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= TBP_RP_IDLE;
            idx <= '0;
            active_o <= 1'b0;
        end else begin
            case (state)
                TBP_RP_IDLE: begin
                    if (select_key_i && panel_function_selector_i == TBP_REPLAY_FN) begin
                        state <= TBP_RP_ARMED;
                    end
                end
                TBP_RP_ARMED: begin
                    if (lower_key_i || select_key_i) begin
                        state <= TBP_RP_IDLE;
                    end else if (raise_key_i) begin
                        state <= TBP_RP_PLAY;
                        idx <= TBP_IDX_ZERO;
                        active_o <= 1'b1;
                    end
                end
                TBP_RP_PLAY: begin
                    if (lower_key_i) begin
                        state <= TBP_RP_IDLE; // RULE14
                        active_o <= 1'b0;
                    end else if (tick) begin
                        if (idx != TBP_LAST_IDX) begin
                            idx <= idx + TBP_IDX_ONE; // RULE12
                        end else if (replay_mode_sel_i == TBP_MODE_CONT) begin
                            idx <= TBP_IDX_ZERO; // RULE11 RULE19
                        end else begin
                            state <= TBP_RP_IDLE; // RULE11 RULE20
                            active_o <= 1'b0;
                        end
                    end
                end
                default: begin
                    state <= TBP_RP_IDLE;
                    active_o <= 1'b0;
                end
            endcase
        end
    end

    // outputs keep the last value after a pass ends or is aborted
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aout_o <= '0;
        end else if (state == TBP_RP_PLAY && tick && !lower_key_i) begin
            aout_o <= play.rd_data; // RULE9 RULE12 RULE20
        end
    end
endmodule // tbp_replay

// ### logic/tbp_trace_buffer.sv
// trace buffer recording, read-out formatting and analog replay top
// How it works
// RULE1: per-channel read-out only answers for indexes 0 through 99.
// RULE2: trigger index equals 127 minus the trigger delay line count.
// RULE3: the trigger position is readable once a recording completes.
// RULE4: a manual stop leaves the trigger position flagged invalid.
// RULE5: with interval N, a line is stored every Nth firing pulse.
// RULE6: after recording ends, the count of stored lines per channel is reported.
// RULE7: trigger at start gives no pre-trigger lines; count equals delay lines.
// RULE8: read-out shows raw hex or percent where 16384 is 100 percent.
// RULE9: first four channels replay to four analog outputs, full signed scale.
// RULE10: replay rate is 300 divided by the speed setting, values per second.
// RULE11: mode 1 plays one pass, mode 2 repeats continuously.
// RULE12: each output plays all 128 values of its channel in order.
// RULE13: operator starts replay with selector 19, select key, then raise key.
// RULE14: lower key aborts a replay at any moment.
// RULE15: for an oscilloscope, speed 1 and mode 2 are recommended.
// RULE16: the store holds 128 lines of eight simultaneous channel values.
// RULE17: writing start begins recording; device clears control after post capture.
// RULE18: sampling interval is a whole number of firing pulse periods.
// RULE19: continuous mode wraps from the last value to the first without gap.
// RULE20: single pass stops after value 128 and holds it.
`timescale 1ns/1ps
module tbp_trace_buffer #(
    parameter int REPLAY_BASE_CYC = tbp_pkg::TBP_REPLAY_BASE_CYC
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic firing_pulse_i,
    input wire logic trigger_cond_i,
    input wire logic [tbp_pkg::TBP_CHANNELS-1:0][tbp_pkg::TBP_DATA_W-1:0] channel_data_i,
    input wire logic record_start_wr_i,
    input wire logic record_stop_wr_i,
    input wire logic [tbp_pkg::TBP_INTERVAL_W-1:0] sampling_interval_i,
    input wire logic [tbp_pkg::TBP_IDX_W-1:0] trigger_delay_lines_i,
    input wire logic [tbp_pkg::TBP_IDX_W-1:0] readout_index_i,
    input wire logic [2:0] readout_channel_i,
    input wire logic display_format_sel_i,
    input wire logic [7:0] panel_function_selector_i,
    input wire logic select_key_i,
    input wire logic raise_key_i,
    input wire logic lower_key_i,
    input wire logic [tbp_pkg::TBP_SPEED_W-1:0] replay_speed_div_i,
    input wire logic [1:0] replay_mode_sel_i,
    output logic record_start_ctrl_o,
    output logic [tbp_pkg::TBP_IDX_W-1:0] trigger_position_o,
    output logic trigger_position_valid_o,
    output logic [tbp_pkg::TBP_COUNT_W-1:0] recorded_count_o,
    output logic [tbp_pkg::TBP_DATA_W-1:0] readout_value_o,
    output logic readout_ok_o,
    output logic [tbp_pkg::TBP_DATA_W-1:0] analog_out_one_o,
    output logic [tbp_pkg::TBP_DATA_W-1:0] analog_out_two_o,
    output logic [tbp_pkg::TBP_DATA_W-1:0] analog_out_three_o,
    output logic [tbp_pkg::TBP_DATA_W-1:0] analog_out_four_o,
    output logic replay_active_o
);
    import tbp_pkg::*;

    // logical line index (0 = oldest shown line) to physical store slot
    function automatic logic [TBP_IDX_W-1:0] log2phys(input logic [TBP_IDX_W-1:0] base,
                                                      input logic [TBP_IDX_W-1:0] lidx);
        log2phys = base + lidx;
    endfunction

    logic [TBP_DATA_W-1:0] store [TBP_LINES][TBP_CHANNELS];
    logic [TBP_IDX_W-1:0] wr_ptr;
    logic [TBP_INTERVAL_W-1:0] div_cnt;
    logic [TBP_INTERVAL_W-1:0] div_last;
    logic [TBP_IDX_W-1:0] post_cnt;
    logic [TBP_IDX_W-1:0] trig_phys;
    logic [TBP_IDX_W-1:0] base;
    logic trig_seen;
    logic store_now;
    logic trig_hit;
    logic [TBP_IDX_W-1:0] trig_line;
    logic post_done;
    logic rec_done;
    logic [TBP_IDX_W-1:0] rd_phys;
    logic [TBP_DATA_W-1:0] rd_raw;
    logic signed [26:0] pct_full;
    logic signed [26:0] pct_shift;
    tbp_play_data_t aout;

    tbp_play_if play ();

    // an interval of zero is treated like one: store on every firing pulse
    assign div_last = (sampling_interval_i == '0) ? '0 : sampling_interval_i - 7'h01;
    assign store_now = record_start_ctrl_o && firing_pulse_i
                       && (div_cnt >= div_last); // RULE5 RULE18
    assign trig_hit = trig_seen || trigger_cond_i;
    assign trig_line = trig_seen ? trig_phys : wr_ptr;
    // the trigger line itself is the first post-trigger line
    assign post_done = (post_cnt + TBP_IDX_ONE) >= trigger_delay_lines_i;
    // capture ends on this store edge; a start without a stop restarts instead
    assign rec_done = store_now && trig_hit && post_done
                      && (record_stop_wr_i || !record_start_wr_i);

    // no reset on the store: contents are only meaningful after a recording
    always_ff @(posedge ref_clk_i) begin
        if (store_now) begin
            for (int c = 0; c < TBP_CHANNELS; c++) begin
                store[wr_ptr][c] <= channel_data_i[c]; // RULE16
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_cnt <= '0;
        end else if (!record_start_ctrl_o || store_now) begin
            div_cnt <= '0;
        end else if (firing_pulse_i) begin
            div_cnt <= div_cnt + 7'h01; // RULE5
        end
    end

    // recording control; a stop written in the same cycle as a start wins,
    // but a capture that completes on the edge of a stop keeps its result
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            record_start_ctrl_o <= 1'b0;
            wr_ptr <= '0;
            post_cnt <= '0;
            trig_phys <= '0;
            trig_seen <= 1'b0;
            base <= '0;
            recorded_count_o <= '0;
        end else if (record_stop_wr_i && !rec_done) begin
            record_start_ctrl_o <= 1'b0;
            base <= (recorded_count_o == TBP_COUNT_FULL) ? wr_ptr : TBP_IDX_ZERO;
        end else if (record_start_wr_i && !record_stop_wr_i) begin
            record_start_ctrl_o <= 1'b1; // RULE17
            wr_ptr <= '0;
            post_cnt <= '0;
            trig_seen <= 1'b0;
            recorded_count_o <= '0;
        end else if (store_now) begin
            wr_ptr <= wr_ptr + TBP_IDX_ONE;
            if (recorded_count_o != TBP_COUNT_FULL) begin
                recorded_count_o <= recorded_count_o + 8'h01; // RULE6 RULE7
            end
            if (trigger_cond_i && !trig_seen) begin
                trig_seen <= 1'b1;
                trig_phys <= wr_ptr;
            end
            if (trig_hit) begin
                post_cnt <= post_cnt + TBP_IDX_ONE;
            end
            if (rec_done) begin
                record_start_ctrl_o <= 1'b0; // RULE17
                base <= trig_line - (TBP_LAST_IDX - trigger_delay_lines_i); // RULE2
            end
        end
    end

    // trigger result: the flag set by a completion wins over a clearing write
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trigger_position_o <= '0;
            trigger_position_valid_o <= 1'b0;
        end else if (rec_done) begin
            trigger_position_o <= TBP_LAST_IDX - trigger_delay_lines_i; // RULE2
            trigger_position_valid_o <= 1'b1; // RULE3
        end else if (record_stop_wr_i) begin
            trigger_position_valid_o <= 1'b0; // RULE4
        end else if (record_start_wr_i) begin
            trigger_position_valid_o <= 1'b0;
        end
    end

    // the store is read live: a new recording changes what read-out shows
    assign rd_phys = log2phys(base, readout_index_i);
    assign rd_raw = store[rd_phys][readout_channel_i];
    assign pct_full = 27'(signed'(rd_raw)) * TBP_PCT_TENTHS;
    assign pct_shift = pct_full >>> TBP_FULL_SCALE_SHIFT;

    // value shown in hex raw, or in tenths of a percent of 16384
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            readout_value_o <= TBP_DATA_RESET;
            readout_ok_o <= 1'b0;
        end else if (readout_index_i <= TBP_READ_MAX_IDX) begin
            readout_ok_o <= 1'b1; // RULE1
            if (display_format_sel_i == TBP_FMT_PCT) begin
                readout_value_o <= pct_shift[15:0]; // RULE8
            end else begin
                readout_value_o <= rd_raw; // RULE8
            end
        end else begin
            readout_ok_o <= 1'b0; // RULE1
            readout_value_o <= TBP_DATA_RESET;
        end
    end

    // replay fetch: slot k carries record channel k, logical order from the base
    generate
        for (genvar k = 0; k < TBP_PLAY_CH; k++) begin : g_fetch
            assign play.rd_data[k] = store[log2phys(base, play.rd_idx)][k]; // RULE9 RULE12
        end
    endgenerate

    // replay walks the same logical order as the panel read-out
    tbp_replay #(
        .BASE_CYC(REPLAY_BASE_CYC)
    ) u_replay (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .play(play.player),
        .panel_function_selector_i(panel_function_selector_i),
        .select_key_i(select_key_i),
        .raise_key_i(raise_key_i),
        .lower_key_i(lower_key_i),
        .replay_speed_div_i(replay_speed_div_i),
        .replay_mode_sel_i(replay_mode_sel_i),
        .aout_o(aout),
        .active_o(replay_active_o)
    );

    // the store port of the interface is driven by the generate above
    assign analog_out_one_o = aout[0];
    assign analog_out_two_o = aout[1];
    assign analog_out_three_o = aout[2];
    assign analog_out_four_o = aout[3];
endmodule // tbp_trace_buffer

// ### testbench/tbp_trace_buffer_monitor.sv
// concurrent checks on the trace buffer top ports
`timescale 1ns/1ps
module tbp_trace_buffer_monitor (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic firing_pulse_i,
    input wire logic record_start_wr_i,
    input wire logic record_stop_wr_i,
    input wire logic [6:0] trigger_delay_lines_i,
    input wire logic [6:0] readout_index_i,
    input wire logic lower_key_i,
    input wire logic [1:0] replay_mode_sel_i,
    input wire logic record_start_ctrl_o,
    input wire logic [6:0] trigger_position_o,
    input wire logic trigger_position_valid_o,
    input wire logic [7:0] recorded_count_o,
    input wire logic [15:0] readout_value_o,
    input wire logic readout_ok_o,
    input wire logic [15:0] analog_out_one_o,
    input wire logic replay_active_o
);
    import tbp_pkg::*;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // past reset guard: the first edge after release still holds outputs at zero
    read_ok_a: assert property ($past(arst_n_i) && readout_index_i <= TBP_READ_MAX_IDX |=> readout_ok_o)
        else $error("read-out refused in range");
    read_refused_a: assert property ($past(arst_n_i)
        && readout_index_i > TBP_READ_MAX_IDX |=> !readout_ok_o && readout_value_o == 16'h0000)
        else $error("read-out answered out of range");
    trig_pos_a: assert property ($fell(record_start_ctrl_o) && trigger_position_valid_o
        |-> trigger_position_o == TBP_LAST_IDX - trigger_delay_lines_i)
        else $error("trigger position wrong");
    stop_invalid_a: assert property (record_stop_wr_i
        |=> !record_start_ctrl_o && (!trigger_position_valid_o || $rose(trigger_position_valid_o)))
        else $error("manual stop left position valid");
    start_clear_a: assert property (record_start_wr_i && !record_stop_wr_i
        |=> record_start_ctrl_o && recorded_count_o == 8'h00)
        else $error("start did not begin recording");
    count_hold_a: assert property (!(firing_pulse_i && record_start_ctrl_o)
        && !record_start_wr_i |=> $stable(recorded_count_o))
        else $error("count moved without a store");
    abort_key_a: assert property (lower_key_i && replay_active_o |=> !replay_active_o)
        else $error("lower key did not abort");
    out_hold_a: assert property (!replay_active_o |=> $stable(analog_out_one_o))
        else $error("output moved while idle");
    cont_play_a: assert property (replay_active_o && replay_mode_sel_i == TBP_MODE_CONT
        && !lower_key_i |=> replay_active_o)
        else $error("continuous replay stopped");
endmodule // tbp_trace_buffer_monitor

bind tbp_trace_buffer tbp_trace_buffer_monitor tbp_trace_buffer_monitor_i (.ref_clk_i, .arst_n_i,
    .firing_pulse_i, .record_start_wr_i, .record_stop_wr_i, .trigger_delay_lines_i,
    .readout_index_i, .lower_key_i, .replay_mode_sel_i, .record_start_ctrl_o,
    .trigger_position_o, .trigger_position_valid_o, .recorded_count_o, .readout_value_o,
    .readout_ok_o, .analog_out_one_o, .replay_active_o);

// ### testbench/tbp_panel_model.sv
// operator panel model: function selector and keys
`timescale 1ns/1ps
module tbp_panel_model (
    input wire logic ref_clk_i,
    input wire logic start_i,
    input wire logic abort_i,
    output logic [7:0] panel_function_selector_o,
    output logic select_key_o,
    output logic raise_key_o,
    output logic lower_key_o
);
    import tbp_pkg::*;
    // one process drives every key, so each output has a single driver
    initial begin
        panel_function_selector_o = 8'h00;
        select_key_o = 1'b0;
        raise_key_o = 1'b0;
        lower_key_o = 1'b0;
        // keys are one-cycle presses with a gap, as an operator cannot press two at once
        forever begin
            @(posedge ref_clk_i);
            if (start_i) begin
                panel_function_selector_o <= TBP_REPLAY_FN;
                select_key_o <= 1'b1;
                @(posedge ref_clk_i) select_key_o <= 1'b0;
                @(posedge ref_clk_i) raise_key_o <= 1'b1;
                @(posedge ref_clk_i) raise_key_o <= 1'b0;
            end
            lower_key_o <= abort_i;
        end
    end
endmodule // tbp_panel_model

// ### testbench/tbp_trace_buffer_test.sv
// self-checking bench for the trace buffer playback block
`timescale 1ns/1ps
module tbp_trace_buffer_test;
    import tbp_pkg::*;
    localparam int BASE = 4;
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic firing_pulse_i = 1'b0;
    logic trigger_cond_i = 1'b0;
    logic [TBP_CHANNELS-1:0][TBP_DATA_W-1:0] channel_data_i = '0;
    logic record_start_wr_i = 1'b0;
    logic record_stop_wr_i = 1'b0;
    logic [6:0] sampling_interval_i = 7'h01;
    logic [6:0] trigger_delay_lines_i = 7'h01;
    logic [6:0] readout_index_i = 7'h00;
    logic [2:0] readout_channel_i = 3'h0;
    logic display_format_sel_i = 1'b0;
    logic [7:0] replay_speed_div_i = 8'h01;
    logic [1:0] replay_mode_sel_i = 2'h1;
    logic p_start = 1'b0;
    logic p_abort = 1'b0;
    logic [7:0] panel_function_selector_i;
    logic select_key_i, raise_key_i, lower_key_i, record_start_ctrl_o;
    logic trigger_position_valid_o, readout_ok_o, replay_active_o;
    logic [6:0] trigger_position_o;
    logic [7:0] recorded_count_o;
    logic [15:0] readout_value_o, analog_out_one_o, analog_out_two_o;
    logic [15:0] analog_out_three_o, analog_out_four_o;
    logic [15:0] slots [128][8];
    int miscompares = 0;
    int samples_checked = 0;
    int nlines = 0;
    int base = 0;
    tbp_trace_buffer #(.REPLAY_BASE_CYC(BASE)) tbp_trace_buffer_i (.*);
    tbp_panel_model tbp_panel_model_i (.ref_clk_i, .start_i(p_start), .abort_i(p_abort),
        .panel_function_selector_o(panel_function_selector_i), .select_key_o(select_key_i),
        .raise_key_o(raise_key_i), .lower_key_o(lower_key_i));
    initial forever #50 ref_clk_i = ~ref_clk_i;
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    // line number in the high byte keeps neighbouring lines distinct for change detection
    task automatic pulse(input logic t);
        logic [15:0] v;
        @(posedge ref_clk_i);
        for (int c = 0; c < 8; c++) begin
            v = {nlines[7:0], 8'($urandom)};
            channel_data_i[c] <= v;
            slots[nlines % 128][c] = v;
        end
        firing_pulse_i <= 1'b1;
        trigger_cond_i <= t;
        nlines++;
        @(posedge ref_clk_i);
        firing_pulse_i <= 1'b0;
    endtask
    task automatic rec(input int iv, input int dl);
        @(posedge ref_clk_i);
        sampling_interval_i <= 7'(iv);
        trigger_delay_lines_i <= 7'(dl);
        record_start_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        record_start_wr_i <= 1'b0;
        nlines = 0;
    endtask
    task automatic play(input int d, input int m, input int n);
        int gap;
        logic [15:0] last;
        @(posedge ref_clk_i);
        replay_speed_div_i <= 8'(d);
        replay_mode_sel_i <= 2'(m);
        p_start <= 1'b1;
        @(posedge ref_clk_i);
        p_start <= 1'b0;
        for (int j = 0; j < n; j++) begin
            last = analog_out_one_o;
            gap = 0;
            while (analog_out_one_o === last && gap < 1000) begin
                @(posedge ref_clk_i);
                gap++;
            end
            if (j > 0) chk("period", 16'(BASE * d), 16'(gap));
            chk("out one", slots[(base + j) % 128][0], analog_out_one_o);
            chk("out two", slots[(base + j) % 128][1], analog_out_two_o);
            chk("out three", slots[(base + j) % 128][2], analog_out_three_o);
            chk("out four", slots[(base + j) % 128][3], analog_out_four_o);
        end
    endtask
    initial begin
        #(3000 * 100);
        miscompares++;
        end_sim();
    end
    initial begin
        int fixed[4] = '{0, 99, 100, 127};
        int ri;
        int ch;
        int pv;
        logic [15:0] v;
        void'($urandom(69));
        tick(5);
        arst_n_i <= 1'b1;
        rec(1, 6);
        repeat (6) pulse(1'b1);
        tick(2);
        chk("count", 16'h0006, 16'(recorded_count_o));
        chk("position", 16'h0079, 16'(trigger_position_o));
        chk("valid", 16'h0001, 16'(trigger_position_valid_o));
        rec(3, 1);
        repeat (9) pulse(1'b0);
        tick(2);
        chk("count", 16'h0003, 16'(recorded_count_o));
        record_stop_wr_i <= 1'b1;
        tick(1);
        record_stop_wr_i <= 1'b0;
        tick(2);
        chk("valid", 16'h0000, 16'(trigger_position_valid_o));
        chk("count", 16'h0003, 16'(recorded_count_o));
        rec(1, 77);
        for (int i = 0; i < 217; i++) pulse(i == 140);
        tick(2);
        chk("ctrl", 16'h0000, 16'(record_start_ctrl_o));
        chk("count", 16'h0080, 16'(recorded_count_o));
        chk("position", 16'h0032, 16'(trigger_position_o));
        base = (nlines - 127) % 128;
        for (int k = 0; k < 24; k++) begin
            ri = (k < 4) ? fixed[k] : $urandom_range(127);
            ch = $urandom_range(7);
            readout_index_i <= 7'(ri);
            readout_channel_i <= 3'(ch);
            display_format_sel_i <= k[0];
            tick(2);
            v = slots[(base + ri) % 128][ch];
            pv = ($signed(v) * 1000) >>> 14;
            if (k[0]) v = pv[15:0];
            if (ri > 99) v = 16'h0000;
            chk("readout", v, readout_value_o);
            chk("readout ok", 16'(ri <= 99), 16'(readout_ok_o));
        end
        play(2, 1, 128);
        tick(BASE * 4);
        chk("active", 16'h0000, 16'(replay_active_o));
        chk("held", slots[(base + 127) % 128][0], analog_out_one_o);
        play(1, 2, 131);
        chk("active", 16'h0001, 16'(replay_active_o));
        p_abort <= 1'b1;
        tick(1);
        p_abort <= 1'b0;
        tick(3);
        chk("active", 16'h0000, 16'(replay_active_o));
        end_sim();
    end
endmodule // tbp_trace_buffer_test
